/* src/uart_irq_wake.sv */
// Purpose: Interrupt request, address-detect qualification and wake-up logic of a serial port.
// Assumes: Datapath supplies one-cycle set and clear pulses and the last received word.
// Notes:   Status flags only advance while the serial clock runs, so contents survive power down.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Any of six sources pulses request low
// - Four flagged sources gated by their enables
// - Separate transmit enables, one shared receive enable
// - Receive transfer and overrun request when enabled
// - Address detect requests without flag when enabled
// - Flags cleared only by serial-port actions
// - Address mode: request only if top bit set
// - Normal mode: every receive transfer requests
// - Transfers pause while serial clock off
// - Register contents kept through idle or sleep
// - Armed falling line edge triggers wake request
// - Without all enables wake gives no interrupt
// - Wake interrupt delayed until restart interval ends
// - Line data ignored during restart interval
// - Vector only with enables and stack room
module uart_irq_wake
  import uart_irq_pkg::*;
#(
  parameter int unsigned RESTART_LEN = uart_irq_pkg::RESTART_CYCLES
) (
  // Clock, reset, clock enable
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  // Serial-port control bits
  input  wire uart_irq_pkg::ctrl_s   ctrl,
  // CPU interrupt controller enables
  input  wire logic                  global_irq_en,
  input  wire logic                  multifunc_irq_en,
  input  wire logic                  serial_irq_en,
  input  wire logic                  stack_full,
  // Datapath events
  input  wire uart_irq_pkg::flags_s  flag_set,
  input  wire uart_irq_pkg::flags_s  flag_clr,
  input  wire logic                  rx_xfer,
  input  wire logic [8:0]            rx_word,
  // Power and line
  input  wire logic                  serial_clk_on,
  input  wire logic                  rx_line,
  // Status and requests
  output uart_irq_pkg::flags_s       status,
  output logic                       irq_b,
  output logic                       cpu_vector,
  output logic                       wake_req,
  output logic                       xfer_run,
  output logic                       rx_ignore
);
  import uart_irq_pkg::*;

  // Refuse restart lengths that the down-counter cannot hold.
  if (RESTART_LEN < 2 || RESTART_LEN >= (1 << RESTART_W)) begin : g_len_chk
    $error("RESTART_LEN out of range");
  end

  localparam logic [RESTART_W-1:0] RESTART_LOAD = RESTART_W'(RESTART_LEN);

  flags_s               flag_q;
  pwr_e                 pwr_q;
  logic [RESTART_W-1:0] cnt_q;
  logic                 wake_pend_q;
  logic                 irq_q;
  logic                 vec_q;
  logic                 wake_req_q;
  logic                 wake_evt;
  logic                 arm;
  logic                 run;
  logic                 rx_msb;
  logic                 src_tx_empty;
  logic                 src_tx_idle;
  logic                 src_rx;
  logic                 src_ovr;
  logic                 src_addr;
  logic                 src_wake;
  logic                 req;
  logic                 wake_irq_ok;

  // Pick the top received bit by word length.
  function automatic logic top_bit(input logic [8:0] w, input logic nine);
    top_bit = nine ? w[8] : w[7];
  endfunction : top_bit

  // Logic advances only while the serial clock runs and no restart is pending.
  assign run      = clk_en && serial_clk_on && (pwr_q == PWR_RUN);
  assign xfer_run = run;
  assign rx_ignore = (pwr_q == PWR_RESTART);
  assign arm = ctrl.wake_en && ctrl.serial_port_en && ctrl.receiver_en && ctrl.rx_irq_en
               && (pwr_q == PWR_OFF);

  wake_edge_det u_wake (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .rx_line    (rx_line),
    .arm        (arm),
    .edge_pulse (wake_evt)
  );

  // Status flags: set by the datapath, cleared only by its own clear pulses; set wins.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flag_q <= FLAGS_RST;
    end else if (run) begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end
  assign status = flag_q;

  // Source qualification for the request line.
  assign rx_msb       = top_bit(rx_word, ctrl.nine_bit_sel);
  assign src_tx_empty = ctrl.tx_empty_irq_en && flag_set.tx_empty && !flag_q.tx_empty;
  assign src_tx_idle  = ctrl.tx_idle_irq_en && flag_set.tx_idle && !flag_q.tx_idle;
  assign src_rx       = ctrl.rx_irq_en && rx_xfer && (!ctrl.addr_detect_en || rx_msb);
  assign src_ovr      = ctrl.rx_irq_en && flag_set.overrun && !flag_q.overrun;
  assign src_addr     = ctrl.addr_detect_en && rx_xfer && rx_msb;
  assign wake_irq_ok  = global_irq_en && multifunc_irq_en && serial_irq_en;
  assign src_wake     = (pwr_q == PWR_RESTART) && (cnt_q == RESTART_W'(1)) && wake_pend_q
                        && wake_irq_ok && clk_en;
  assign req = (run && (src_tx_empty || src_tx_idle || src_rx || src_ovr || src_addr))
               || src_wake;

  // Power state: off while the serial clock is stopped, then a fixed restart interval.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pwr_q       <= PWR_RUN;
      cnt_q       <= '0;
      wake_pend_q <= 1'b0;
    end else if (clk_en) begin
      case (pwr_q)
        PWR_RUN: begin
          if (!serial_clk_on) begin
            pwr_q <= PWR_OFF;
          end
        end
        PWR_OFF: begin
          if (wake_evt || serial_clk_on) begin
            pwr_q       <= PWR_RESTART;
            cnt_q       <= RESTART_LOAD;
            wake_pend_q <= wake_evt;
          end
        end
        PWR_RESTART: begin
          if (cnt_q == RESTART_W'(1)) begin
            pwr_q       <= PWR_RUN;
            wake_pend_q <= 1'b0;
          end
          cnt_q <= cnt_q - RESTART_W'(1);
        end
        default: begin
          pwr_q <= PWR_RUN;
        end
      endcase
    end
  end

  // Request pulse, vector pulse and wake pulse, each one cycle long.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_q      <= 1'b0;
      vec_q      <= 1'b0;
      wake_req_q <= 1'b0;
    end else if (clk_en) begin
      irq_q      <= req;
      vec_q      <= req && global_irq_en && multifunc_irq_en && serial_irq_en
                    && !stack_full;
      wake_req_q <= wake_evt && (pwr_q == PWR_OFF);
    end
  end
  assign irq_b      = ~irq_q;
  assign cpu_vector = vec_q;
  assign wake_req   = wake_req_q;

  // Assertions on the request, vector, wake, status, rx_ignore and xfer_run outputs.
  rx_qual_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && run && rx_xfer && ctrl.rx_irq_en && !ctrl.addr_detect_en) |=> !irq_b)
    else $error("receive transfer gave no request");
  addr_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && run && ctrl.addr_detect_en && !rx_msb && !src_tx_empty && !src_tx_idle
     && !src_ovr && !src_wake) |=> irq_b)
    else $error("data word raised request in address mode");
  addr_req_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (run && rx_xfer && ctrl.addr_detect_en && rx_msb) |=> !irq_b)
    else $error("address word gave no request");
  irq_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && req) |=> !irq_b)
    else $error("request pulse missing");
  irq_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && !req) |=> irq_b)
    else $error("request line low without a source");
  flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!run) |=> (status == $past(status)))
    else $error("status changed while paused");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (run && |(flag_set & flag_clr))
    |=> ((status & $past(flag_set & flag_clr)) == $past(flag_set & flag_clr)))
    else $error("clear beat set on status flag");
  vec_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && stack_full) |=> !cpu_vector)
    else $error("vector while stack full");
  vec_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && req && wake_irq_ok && !stack_full) |=> cpu_vector)
    else $error("vector missing with all enables");
  restart_ign_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && pwr_q == PWR_OFF && wake_evt) |=> (rx_ignore && !xfer_run)[*2])
    else $error("line not ignored during restart");
  wake_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && pwr_q == PWR_RESTART && cnt_q > RESTART_W'(1)) |=> irq_b)
    else $error("wake request before restart ended");
  wake_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && pwr_q == PWR_RESTART && !wake_irq_ok) |=> irq_b)
    else $error("wake interrupt without enables");
  wake_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && pwr_q == PWR_OFF && wake_evt) |=> wake_req)
    else $error("line wake not reported");
  arm_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clk_en && pwr_q != PWR_OFF) |=> !wake_req)
    else $error("wake reported while serial clock runs");

endmodule : uart_irq_wake
`default_nettype wire

/* src/uart_irq_pkg.sv */
// Purpose: Shared types and constants for the serial-port interrupt and wake block.
// Assumes: One system clock; all control bits arrive as plain levels.
// Notes:   The restart count is a plain default and can be overridden per instance.
package uart_irq_pkg;

  // Cycles of the system-clock restart interval after a wake-up.
  localparam int unsigned RESTART_CYCLES = 1024;
  // Width of the restart down-counter.
  localparam int unsigned RESTART_W      = 16;

  // Power state of the serial clock domain.
  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_OFF     = 2'b01,
    PWR_RESTART = 2'b10
  } pwr_e;

  // Control bits from the two serial control registers and the port enables.
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_idle_irq_en;
    logic rx_irq_en;
    logic addr_detect_en;
    logic wake_en;
    logic serial_port_en;
    logic receiver_en;
    logic nine_bit_sel;
    logic parity_en;
  } ctrl_s;

  // Status flags of the serial status register.
  typedef struct packed {
    logic tx_empty;
    logic tx_idle;
    logic rx_avail;
    logic overrun;
  } flags_s;

  // Value of the status flags after reset.
  localparam flags_s FLAGS_RST = '{tx_empty: 1'b0, tx_idle: 1'b0, rx_avail: 1'b0, overrun: 1'b0};

endpackage : uart_irq_pkg

/* src/wake_edge_det.sv */
// Purpose: Catch a falling edge on the serial line while the serial clock is stopped.
// Assumes: arm is steady while the line is watched; ref_clk may run slowly or be gated.
// Notes:   The capture flop is clocked by the line itself, so no system edge is needed.
`timescale 1ns/1ps
`default_nettype none
module wake_edge_det (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Line and arming
  input  wire logic rx_line,
  input  wire logic arm,
  // Event toward the system domain
  output logic      edge_pulse
);

  logic tog_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  // Toggle on each armed falling line edge; works with no system clock at all.
  always_ff @(negedge rx_line or negedge rst_b) begin
    if (!rst_b) begin
      tog_q <= 1'b0;
    end else if (arm) begin
      tog_q <= ~tog_q;
    end
  end

  // Two-flop synchroniser plus one history stage for the toggle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= tog_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change of the synchronised toggle marks one edge.
  assign edge_pulse = sync2_q ^ sync3_q;

endmodule : wake_edge_det
`default_nettype wire

/* tb/cpu_irq_model.sv */
// Purpose: Stand-in for the CPU interrupt controller that tallies serial-port requests.
// Assumes: Requests are one-cycle pulses sampled on the rising clock edge.
// Notes:   Tallies clear in reset; the bench compares differences.
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Requests from the serial port
  input  wire logic irq_b,
  input  wire logic cpu_vector,
  input  wire logic wake_req,
  // Tallies seen by the bench
  output var  int   irq_cnt,
  output var  int   vec_cnt,
  output var  int   wake_cnt
);
  // Count each low request cycle, each vector taken and each wake event.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_cnt  <= 0;
      vec_cnt  <= 0;
      wake_cnt <= 0;
    end else begin
      irq_cnt  <= irq_cnt + int'(irq_b === 1'b0);
      vec_cnt  <= vec_cnt + int'(cpu_vector === 1'b1);
      wake_cnt <= wake_cnt + int'(wake_req === 1'b1);
    end
  end
endmodule : cpu_irq_model
`default_nettype wire

/* tb/uart_irq_wake_tb.sv */
// Purpose: Self-checking bench for the serial-port interrupt and wake block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   A short restart interval keeps the wake runs brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("unexpected %0t got %0h want %0h", $time, (a), (e)); \
  end \
end
module uart_irq_wake_tb;
  import uart_irq_pkg::*;
  localparam int RLEN = 4;
  // Design inputs at their idle values.
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b1;
  logic       clk_en = 1'b1;
  logic       global_irq_en = 1'b1;
  logic       multifunc_irq_en = 1'b1;
  logic       serial_irq_en = 1'b1;
  logic       stack_full = 1'b0;
  logic       rx_xfer = 1'b0;
  logic       serial_clk_on = 1'b1;
  logic       rx_line = 1'b1;
  logic [8:0] rx_word = '0;
  ctrl_s      ctrl = '0;
  flags_s     flag_set = '0;
  flags_s     flag_clr = '0;
  // Design outputs and tallies.
  flags_s     status;
  logic       irq_b, cpu_vector, wake_req, xfer_run, rx_ignore;
  int         irq_cnt, vec_cnt, wake_cnt, i0, v0, w0;
  int         err_total = 0;
  int         num_checks = 0;

  // Free-running system clock.
  always #2 ref_clk = ~ref_clk;

  uart_irq_wake #(.RESTART_LEN(RLEN)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .ctrl(ctrl), .global_irq_en(global_irq_en), .multifunc_irq_en(multifunc_irq_en),
    .serial_irq_en(serial_irq_en), .stack_full(stack_full), .flag_set(flag_set),
    .flag_clr(flag_clr), .rx_xfer(rx_xfer), .rx_word(rx_word), .serial_clk_on(serial_clk_on),
    .rx_line(rx_line), .status(status), .irq_b(irq_b), .cpu_vector(cpu_vector),
    .wake_req(wake_req), .xfer_run(xfer_run), .rx_ignore(rx_ignore));

  cpu_irq_model model (.ref_clk(ref_clk), .rst_b(rst_b), .irq_b(irq_b),
    .cpu_vector(cpu_vector), .wake_req(wake_req), .irq_cnt(irq_cnt), .vec_cnt(vec_cnt),
    .wake_cnt(wake_cnt));

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic snap;
    i0 = irq_cnt;
    v0 = vec_cnt;
    w0 = wake_cnt;
  endtask : snap

  // One cycle of set and clear pulses, then time for the request to land.
  task automatic pulse(input flags_s s, input flags_s c);
    flag_set = s;
    flag_clr = c;
    step(1);
    flag_set = '0;
    flag_clr = '0;
    step(3);
  endtask : pulse

  task automatic t_flags;
    flags_s f;
    for (int k = 0; k < 6; k++) begin
      f = (k > 3) ? 4'h1 : 4'h8 >> (k / 2);
      ctrl = k[0] ? (9'h100 >> (k / 2)) : '0;
      snap();
      pulse(f, '0);
      `CHK(status, f)
      `CHK(irq_cnt - i0, int'(k[0]))
      `CHK(vec_cnt - v0, int'(k[0]))
      pulse(f, f);
      `CHK(status, f)
      pulse('0, f);
      `CHK(status, FLAGS_RST)
    end
  endtask : t_flags

  task automatic t_gate;
    for (int j = 0; j < 4; j++) begin
      stack_full = (j == 0);
      global_irq_en = (j != 1);
      multifunc_irq_en = (j != 2);
      serial_irq_en = (j != 3);
      ctrl = 9'h100;
      snap();
      pulse(4'h8, '0);
      `CHK(irq_cnt - i0, 1)
      `CHK(vec_cnt - v0, 0)
      pulse('0, 4'h8);
    end
    stack_full = 1'b0;
    global_irq_en = 1'b1;
    multifunc_irq_en = 1'b1;
    serial_irq_en = 1'b1;
  endtask : t_gate

  // Clock enable low freezes flags and requests and drops the pulse; a repeated pulse lands once enabled.
  task automatic t_hold;
    ctrl = 9'h100;
    snap();
    clk_en = 1'b0;
    pulse(4'h8, '0);
    `CHK(xfer_run, 1'b0)
    `CHK(status, FLAGS_RST)
    `CHK(irq_cnt - i0, 0)
    clk_en = 1'b1;
    pulse(4'h8, '0);
    `CHK(status, flags_s'(4'h8))
    `CHK(irq_cnt - i0, 1)
    pulse('0, 4'h8);
  endtask : t_hold

  task automatic t_rx;
    logic top;
    for (int k = 0; k < 16; k++) begin
      top = k[0];
      ctrl = '0;
      ctrl.rx_irq_en = k[3];
      ctrl.addr_detect_en = k[2];
      ctrl.nine_bit_sel = k[1];
      rx_word = k[1] ? {top, ~top, 7'h00} : {~top, top, 7'h00};
      snap();
      rx_xfer = 1'b1;
      step(1);
      rx_xfer = 1'b0;
      step(3);
      `CHK(irq_cnt - i0, k[2] ? int'(k[0]) : int'(k[3]))
    end
  endtask : t_rx

  task automatic t_pause;
    int n;
    ctrl = 9'h080;
    pulse(4'h1, '0);
    serial_clk_on = 1'b0;
    rx_line = 1'b0;
    step(2);
    `CHK(xfer_run, 1'b0)
    snap();
    pulse(4'h4, 4'h1);
    `CHK(status, flags_s'(4'h1))
    `CHK(irq_cnt - i0, 0)
    serial_clk_on = 1'b1;
    rx_line = 1'b1;
    n = 0;
    while (xfer_run !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    `CHK(xfer_run, 1'b1)
    `CHK(wake_cnt - w0, 0)
    pulse(4'h4, 4'h1);
    `CHK(status, flags_s'(4'h4))
    `CHK(irq_cnt - i0, 1)
    pulse('0, 4'h4);
  endtask : t_pause

  task automatic t_wake(input logic gi);
    int n;
    global_irq_en = gi;
    ctrl = 9'h05C;
    serial_clk_on = 1'b0;
    step(3);
    snap();
    rx_line = 1'b0;
    n = 0;
    while (wake_req !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    `CHK(wake_req, 1'b1)
    `CHK(rx_ignore, 1'b1)
    serial_clk_on = 1'b1;
    rx_line = 1'b1;
    n = 0;
    while (rx_ignore === 1'b1 && n < 20) begin
      `CHK(irq_cnt - i0, 0)
      step(1);
      n++;
    end
    `CHK(n, RLEN)
    step(1);
    `CHK(irq_cnt - i0, int'(gi))
    `CHK(wake_cnt - w0, 1)
    `CHK(vec_cnt - v0, int'(gi))
    global_irq_en = 1'b1;
  endtask : t_wake

  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Reset for three cycles, then each scenario in turn.
  // The falling reset edge also clears the line-clocked wake capture flop.
  initial begin
    #1;
    rst_b = 1'b0;
    step(3);
    `CHK(status, FLAGS_RST)
    `CHK(irq_b, 1'b1)
    rst_b = 1'b1;
    t_flags();
    t_gate();
    t_hold();
    t_rx();
    t_pause();
    t_wake(1'b1);
    t_wake(1'b0);
    wrap_up();
  end
endmodule : uart_irq_wake_tb
`default_nettype wire
